// ===== design/advanced_stop_condition_checker.sv
// Notes on behaviour
// R1: Enable-word bit 15 and first check met invert enabled second check states.
// R2: State-word bit 15 and first check met invert enabled OR group states.
// R3: Bits 14..12 select and give states of inputs 3, 2, 1 at start.
// R4: Bits 11..8 are the second check; all must hold before last check arms.
// R5: Second check never met lets motion run to its end, no stop.
// R6: Bits 7..4 AND group, 3..0 OR group: index, in3, in2, in1.
// R7: With both groups enabled, stop needs AND result and OR result true.
// R8: Last check met requests stop and loads register 4 with position.
// R9: Enable bit turns monitoring on; same state bit gives watched condition.
// R10: Any enabled first check condition at start reverses direction; start only.
// R11: Any one enabled OR condition suffices to stop.
// R12: Single AND condition alone records position without stopping.
// R13: State bit one requires input high, zero requires input low.
`timescale 1ns/1ps
`default_nettype none
module advanced_stop_condition_checker (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [15:0] enable_word,
  input wire logic [15:0] state_word,
  input wire logic motion_start,
  input wire logic motion_end,
  input wire logic index_in,
  input wire logic input1,
  input wire logic input2,
  input wire logic input3,
  input wire logic [31:0] position,
  output logic reverse_dir,
  output logic stop_request,
  output logic position_captured,
  output logic armed,
  output logic checking,
  output logic [31:0] captured_position
);
  stop_check_pkg::check_state_t state;
  stop_check_pkg::check_state_t next_state;
  logic [15:0] en;
  logic [15:0] st;
  logic [15:0] next_en;
  logic [15:0] next_st;
  logic next_reverse_dir;
  logic next_stop_request;
  logic next_position_captured;
  logic [31:0] next_captured_position;
  logic [3:0] live;
  logic [2:0] first_en;
  logic [2:0] first_hit;
  logic first_met;
  logic [3:0] second_state_eff;
  logic [3:0] or_state_eff;
  logic sec_any;
  logic sec_all;
  logic and_any;
  logic and_all;
  logic and_single;
  logic or_any;
  logic or_some;
  logic last_met;
  logic last_stops;

  // R6: group order index, in3, in2, in1
  assign live = {index_in, input3, input2, input1};

  always_comb begin
    // R3: first check on inputs 3..1
    first_en = en[stop_check_pkg::first_lsb +: stop_check_pkg::first_width];
    // R9: enabled bit compared against its state bit
    first_hit = first_en
      & ~(live[2:0] ^ st[stop_check_pkg::first_lsb +: stop_check_pkg::first_width]);
    // R10: any enabled condition reverses
    first_met = |first_hit;
  end

  always_comb begin
    // R1: invert enabled second check states
    second_state_eff = st[stop_check_pkg::second_lsb +: stop_check_pkg::group_width];
    if (reverse_dir && en[stop_check_pkg::toggle_bit]) begin
      second_state_eff = second_state_eff
        ^ en[stop_check_pkg::second_lsb +: stop_check_pkg::group_width];
    end
    // R2: invert enabled OR states
    or_state_eff = st[stop_check_pkg::or_lsb +: stop_check_pkg::group_width];
    if (reverse_dir && st[stop_check_pkg::toggle_bit]) begin
      or_state_eff = or_state_eff
        ^ en[stop_check_pkg::or_lsb +: stop_check_pkg::group_width];
    end
  end

  group_match second_group (
    .enable(en[stop_check_pkg::second_lsb +: stop_check_pkg::group_width]),
    .state(second_state_eff),
    .inputs(live),
    .any_enabled(sec_any),
    .all_met(sec_all),
    .any_met(),
    .single_enabled()
  );

  group_match and_group (
    .enable(en[stop_check_pkg::and_lsb +: stop_check_pkg::group_width]),
    .state(st[stop_check_pkg::and_lsb +: stop_check_pkg::group_width]),
    .inputs(live),
    .any_enabled(and_any),
    .all_met(and_all),
    .any_met(),
    .single_enabled(and_single)
  );

  group_match or_group (
    .enable(en[stop_check_pkg::or_lsb +: stop_check_pkg::group_width]),
    .state(or_state_eff),
    .inputs(live),
    .any_enabled(or_any),
    .all_met(),
    .any_met(or_some),
    .single_enabled()
  );

  always_comb begin
    last_met = 1'b0;
    last_stops = 1'b0;
    if (and_any && or_any) begin
      // R7: both groups must be true
      last_met = and_all && or_some;
      last_stops = last_met;
    end else if (or_any) begin
      // R11: any OR condition stops
      last_met = or_some;
      last_stops = last_met;
    end else if (and_any) begin
      last_met = and_all;
      // R12: single AND condition only records
      last_stops = last_met && !and_single;
    end
  end

  always_comb begin
    next_state = state;
    next_en = en;
    next_st = st;
    next_reverse_dir = reverse_dir;
    next_stop_request = stop_request;
    next_position_captured = 1'b0;
    next_captured_position = captured_position;
    case (state)
      stop_check_pkg::st_idle: begin
        if (motion_start) begin
          next_en = enable_word;
          next_st = state_word;
          next_reverse_dir = 1'b0;
          next_stop_request = 1'b0;
          next_state = stop_check_pkg::st_second;
        end
      end
      stop_check_pkg::st_second: begin
        // R10: first check evaluated once, at start
        if (!armed) begin
          next_reverse_dir = first_met;
        end
        if (motion_end) begin
          // R5: no stop when never armed
          next_state = stop_check_pkg::st_idle;
        end else if (armed && (!sec_any || sec_all)) begin
          // R4: all enabled second conditions hold
          next_state = stop_check_pkg::st_last;
        end
      end
      stop_check_pkg::st_last: begin
        if (motion_end) begin
          next_state = stop_check_pkg::st_idle;
        end else if (last_met && (and_any || or_any)) begin
          // R8: latch position; stop unless the R12 single AND case
          next_captured_position = position;
          next_position_captured = 1'b1;
          next_stop_request = last_stops;
          next_state = stop_check_pkg::st_done;
        end
      end
      stop_check_pkg::st_done: begin
        if (motion_end) begin
          next_stop_request = 1'b0;
          next_state = stop_check_pkg::st_idle;
        end
      end
      default: begin
        next_state = stop_check_pkg::st_idle;
      end
    endcase
  end

  // Armed marks the first check done; set on the cycle after the words load
  logic next_armed;
  always_comb begin
    next_armed = armed;
    if (state == stop_check_pkg::st_idle) begin
      next_armed = 1'b0;
    end else if (state == stop_check_pkg::st_second) begin
      next_armed = 1'b1;
    end
  end

  assign checking = (state == stop_check_pkg::st_last);

  always_ff @(posedge mclk) begin
    if (reset) begin
      state <= stop_check_pkg::st_idle;
      en <= stop_check_pkg::word_reset;
      st <= stop_check_pkg::word_reset;
      reverse_dir <= 1'b0;
      stop_request <= 1'b0;
      position_captured <= 1'b0;
      armed <= 1'b0;
      captured_position <= stop_check_pkg::pos_reset;
    end else begin
      state <= next_state;
      en <= next_en;
      st <= next_st;
      reverse_dir <= next_reverse_dir;
      stop_request <= next_stop_request;
      position_captured <= next_position_captured;
      armed <= next_armed;
      captured_position <= next_captured_position;
    end
  end
endmodule
`default_nettype wire

// ===== design/group_match.sv
`timescale 1ns/1ps
`default_nettype none
// Per-input match of a four-wide group: enabled bits compared to required states
module group_match (
  input wire logic [3:0] enable,
  input wire logic [3:0] state,
  input wire logic [3:0] inputs,
  output logic any_enabled,
  output logic all_met,
  output logic any_met,
  output logic single_enabled
);
  logic [3:0] hit;

  always_comb begin
    // R13: one means high, zero low
    hit = enable & ~(inputs ^ state);
    any_enabled = |enable;
    all_met = (hit == enable) && (|enable);
    any_met = |hit;
    single_enabled = (enable != 4'h0) && ((enable & (enable - 4'h1)) == 4'h0);
  end
endmodule
`default_nettype wire

// ===== design/stop_check_pkg.sv
package stop_check_pkg;
  localparam int unsigned word_width = 16;
  localparam int unsigned pos_width = 32;
  // Enable and state word fields
  localparam int unsigned toggle_bit = 15;
  localparam int unsigned first_lsb = 12;
  localparam int unsigned first_width = 3;
  localparam int unsigned second_lsb = 8;
  localparam int unsigned and_lsb = 4;
  localparam int unsigned or_lsb = 0;
  localparam int unsigned group_width = 4;
  localparam logic [31:0] pos_reset = 32'h0000_0000;
  localparam logic [15:0] word_reset = 16'h0000;

  typedef enum logic [1:0] {
    st_idle,
    st_second,
    st_last,
    st_done
  } check_state_t;
endpackage

// ===== sim/advanced_stop_condition_checker_bench.sv
`timescale 1ns/1ps
`default_nettype none
module advanced_stop_condition_checker_bench;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic [15:0] enable_word = 16'h0000;
  logic [15:0] state_word = 16'h0000;
  logic motion_start = 1'b0;
  logic motion_end = 1'b0;
  logic [3:0] pat = 4'h0;
  logic [31:0] position = 32'h0000_0000;
  wire index_in, input1, input2, input3;
  logic reverse_dir, stop_request, position_captured, armed, checking;
  logic [31:0] captured_position;
  int num_errors = 0;
  int total_checks = 0;
  always #5 mclk = ~mclk;
  sensor_model u_sensor_model (.pat(pat), .index_in(index_in), .input3(input3),
    .input2(input2), .input1(input1));
  advanced_stop_condition_checker u_advanced_stop_condition_checker (
    .mclk(mclk), .reset(reset), .enable_word(enable_word), .state_word(state_word),
    .motion_start(motion_start), .motion_end(motion_end), .index_in(index_in),
    .input1(input1), .input2(input2), .input3(input3), .position(position),
    .reverse_dir(reverse_dir), .stop_request(stop_request), .armed(armed),
    .position_captured(position_captured), .checking(checking),
    .captured_position(captured_position));
  task chk1(input string n, input logic e, input logic g);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task chk32(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  // One move: p0 at start, p1 after arming, p2 with the capture position
  task mv(input logic [15:0] en, input logic [15:0] st, input logic [3:0] p0,
    input logic [3:0] p1, input logic [3:0] p2, input logic rev, input logic cap,
    input logic stp);
    logic seen;
    @(negedge mclk);
    enable_word = en;
    state_word = st;
    pat = p0;
    position = 32'h0000_0000;
    motion_start = 1'b1;
    @(negedge mclk);
    motion_start = 1'b0;
    repeat (2) @(negedge mclk);
    chk1("reverse_dir", rev, reverse_dir);
    chk1("armed", 1'b1, armed);
    pat = p1;
    @(negedge mclk);
    chk1("checking", cap, checking);
    pat = p2;
    position = {st, en};
    seen = 1'b0;
    for (int i = 0; i < 8 && !seen; i++) begin
      @(negedge mclk);
      seen = (position_captured === 1'b1);
    end
    chk1("capture", cap, seen);
    if (seen) chk32("captured_position", {st, en}, captured_position);
    chk1("stop_request", stp, stop_request);
    motion_end = 1'b1;
    @(negedge mclk);
    motion_end = 1'b0;
    chk1("stop_cleared", 1'b0, stop_request);
  endtask
  task t_or; mv(16'h0001, 16'h0001, 4'h0, 4'h0, 4'h1, 1'b0, 1'b1, 1'b1); endtask
  task t_rev; mv(16'h1001, 16'h9001, 4'h1, 4'h1, 4'h0, 1'b1, 1'b1, 1'b1); endtask
  task t_sec; mv(16'h0801, 16'h0801, 4'h0, 4'h8, 4'h9, 1'b0, 1'b1, 1'b1); endtask
  task t_nosec; mv(16'h0801, 16'h0801, 4'h0, 4'h0, 4'h1, 1'b0, 1'b0, 1'b0); endtask
  task t_tog; mv(16'h9204, 16'h1204, 4'h1, 4'h1, 4'h5, 1'b1, 1'b1, 1'b1); endtask
  task t_andor; mv(16'h0034, 16'h0034, 4'h0, 4'h3, 4'h7, 1'b0, 1'b1, 1'b1); endtask
  task t_single; mv(16'h0080, 16'h0080, 4'h0, 4'h0, 4'h8, 1'b0, 1'b1, 1'b0); endtask
  task end_sim;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    repeat (4) @(negedge mclk);
    reset = 1'b0;
    chk1("idle", 1'b0, |{reverse_dir, stop_request, armed, checking, captured_position});
    t_or;
    t_rev;
    t_sec;
    t_nosec;
    t_tog;
    t_andor;
    t_single;
    end_sim;
  end
  initial begin
    repeat (3000) @(posedge mclk);
    num_errors++;
    end_sim;
  end
endmodule
`default_nettype wire

// ===== sim/sensor_model.sv
`timescale 1ns/1ps
`default_nettype none
// Sensor lines are always driven; pattern order is index, in3, in2, in1
module sensor_model (
  input wire logic [3:0] pat,
  output logic index_in,
  output logic input3,
  output logic input2,
  output logic input1
);
  assign {index_in, input3, input2, input1} = pat;
endmodule
`default_nettype wire

// ===== sim/stop_check_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module stop_monitor (
  input wire logic mclk,
  input wire logic reset,
  input wire logic motion_start,
  input wire logic motion_end,
  input wire logic [31:0] position,
  input wire logic reverse_dir,
  input wire logic stop_request,
  input wire logic position_captured,
  input wire logic armed,
  input wire logic checking,
  input wire logic [31:0] captured_position
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  sequence s_cap;
    position_captured;
  endsequence
  property p_cap_pulse; s_cap |=> !position_captured; endproperty
  a_cap_pulse: assert property (p_cap_pulse) else $error("capture pulse long");
  property p_cap_val; s_cap |-> captured_position == $past(position); endproperty
  a_cap_val: assert property (p_cap_val) else $error("capture value");
  property p_arm; $rose(checking) |-> armed; endproperty
  a_arm: assert property (p_arm) else $error("checking unarmed");
  property p_stop_cause; $rose(stop_request) |-> s_cap; endproperty
  a_stop_cause: assert property (p_stop_cause) else $error("stop no capture");
  property p_cap_cause; s_cap |-> $past(checking); endproperty
  a_cap_cause: assert property (p_cap_cause) else $error("capture not checking");
  property p_stop_hold; stop_request && !motion_end |=> stop_request; endproperty
  a_stop_hold: assert property (p_stop_hold) else $error("stop dropped");
  property p_end_clear; motion_end |=> !stop_request; endproperty
  a_end_clear: assert property (p_end_clear) else $error("stop kept");
  // Cleared one edge after start, set from the first check one edge later
  property p_rev;
    !$stable(reverse_dir) |-> $past(motion_start) || $past(motion_start, 2);
  endproperty
  a_rev: assert property (p_rev) else $error("direction moved");
endmodule
bind advanced_stop_condition_checker stop_monitor u_stop_monitor (
  .mclk(mclk), .reset(reset), .motion_start(motion_start), .motion_end(motion_end),
  .position(position), .reverse_dir(reverse_dir), .stop_request(stop_request),
  .position_captured(position_captured), .armed(armed), .checking(checking),
  .captured_position(captured_position)
);
`default_nettype wire
